// [ddr_byte_read_gating_odt_bench.sv]
// self-checking bench for the read gating and termination block
`timescale 1ns/1ps
`include "ddrbg_params.svh"
`define CHK(g, e) \
  begin \
    total_checks++; \
    if ((g) !== (e)) \
    begin \
      fail_count++; \
      $display("mismatch t=%0t got %h exp %h", $time, g, e); \
    end \
  end
module ddr_byte_read_gating_odt_bench;
  localparam logic [11:0] G = `DDRBG_GCR_ADDR;
  localparam logic [11:0] S = `DDRBG_STR_ADDR;
  localparam logic [11:0] P = `DDRBG_PGC_ADDR;
  logic        mclk = 1'b0, arst_n = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0, rd_req = 1'b0, train_load = 1'b0;
  logic        drift_load = 1'b0;
  logic [3:0]  wb_sel_i = 4'hF;
  logic [11:0] wb_adr_i = 12'h000, train_sys_latency = 12'h000;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
  logic [1:0]  rd_rank = 2'h0;
  logic [7:0]  train_gate_phase = 8'h00, drift_gate_phase = 8'h00;
  logic        wb_ack_o, rd_busy, rd_strobe_gated, rd_gate, rd_strobe_in;
  logic        data_term_out, strobe_term_out, clock_phase_0, clock_phase_90;
  logic        clock_phase_180, clock_phase_270;
  int          tg, tt, gf, tf, sc, t0, a0, f0, c;
  int          fail_count = 0;
  int          total_checks = 0;
  ddrbg_top uut (.*);
  ddrbg_sdram_model far (.*);
  always #12.5 mclk = ~mclk;
  // ==========================================================
  // bus cycle, read data compared with d
  task automatic wb(input logic w, input logic [11:0] a,
                    input logic [31:0] d);
    @(posedge mclk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do
      @(posedge mclk);
    while (wb_ack_o !== 1'b1);
    if (!w)
      `CHK(wb_dat_o, d)
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic load(input logic t, input logic [7:0] p,
                      input logic [11:0] l);
    @(posedge mclk);
    train_load <= t;
    drift_load <= !t;
    train_gate_phase <= p;
    drift_gate_phase <= p;
    train_sys_latency <= l;
    @(posedge mclk);
    train_load <= 1'b0;
    drift_load <= 1'b0;
  endtask
  // ==========================================================
  // read aligned to the link clock, edges logged in cycles
  task automatic rd(input logic [1:0] r);
    int n;
    int k;
    n = 0;
    k = 0;
    {tg, tt, gf, tf, sc} = '0;
    @(posedge clock_phase_0);
    @(posedge mclk);
    rd_req  <= 1'b1;
    rd_rank <= r;
    @(posedge mclk);
    rd_req <= 1'b0;
    while (k < 4)
    begin
      @(negedge mclk);
      n++;
      k = (rd_busy === 1'b0) ? k + 1 : 0;
      if (rd_gate === 1'b1 && tg == 0) tg = n;
      if (data_term_out === 1'b1 && tt == 0) tt = n;
      if (rd_gate === 1'b0 && tg != 0 && gf == 0) gf = n;
      if (data_term_out === 1'b0 && tt != 0 && tf == 0) tf = n;
      if (rd_strobe_gated === 1'b1) sc++;
    end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // ==========================================================
  // tests
  initial
  begin
    repeat (4) @(posedge mclk);
    arst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    wb(1'b0, G, 32'h0000_0681);
    wb(1'b0, S, 32'h0005_5000);
    wb(1'b0, 12'h100, 32'h0);
    wb(1'b1, G, 32'hFFFF_FFFF);
    wb(1'b0, G, 32'h0000_3FFF);
    wb(1'b1, S, 32'hFFFF_FFFF);
    wb(1'b0, S, 32'h000F_FFFF);
    $display("registers done");
    load(1'b1, 8'hE4, 12'hA53);
    wb(1'b0, S, 32'h000E_4A53);
    load(1'b0, 8'h1B, 12'h000);
    wb(1'b0, S, 32'h0001_BA53);
    wb(1'b1, P, 32'h1);
    load(1'b0, 8'hFF, 12'h000);
    wb(1'b0, S, 32'h0001_BA53);
    wb(1'b1, P, 32'h0);
    wb(1'b1, S, 32'h0000_03E8);
    wb(1'b0, S, 32'h0000_03E8);
    $display("loads done");
    wb(1'b1, G, 32'h0000_0404);
    repeat (3) @(negedge mclk);
    `CHK(data_term_out, 1'b0)
    rd(2'h0);
    t0 = tg;
    `CHK(sc != 0, 1'b1)
    `CHK(tt != 0, 1'b1)
    rd(2'h1);
    `CHK(tg - t0, 40)
    rd(2'h2);
    `CHK(tg - t0, 40)
    rd(2'h3);
    `CHK(tg - t0, 8)
    wb(1'b0, `DDRBG_STAT_ADDR, 32'h0000_0030);
    for (c = 1; c < 4; c++)
    begin
      wb(1'b1, S, c << 12);
      rd(2'h0);
      `CHK(tg - t0, 2 * c)
    end
    $display("reads done");
    wb(1'b1, S, 32'h1);
    rd(2'h0);
    a0 = tg - tt;
    wb(1'b1, G, 32'h0000_2404);
    rd(2'h0);
    `CHK(a0 - (tg - tt), 8)
    wb(1'b1, G, 32'h0000_0C04);
    rd(2'h0);
    f0 = tf - gf;
    wb(1'b1, G, 32'h0000_1C04);
    rd(2'h0);
    `CHK(tf - gf - f0, 16)
    wb(1'b1, G, 32'h0000_0004);
    repeat (3) @(negedge mclk);
    `CHK(data_term_out, 1'b1)
    wb(1'b1, G, 32'h0000_0200);
    wb(1'b1, P, 32'h2);
    repeat (3) @(negedge mclk);
    `CHK({data_term_out, strobe_term_out}, 2'b10)
    wb(1'b1, G, 32'h0);
    repeat (3) @(negedge mclk);
    `CHK({data_term_out, strobe_term_out}, 2'b11)
    $display("termination done");
    final_report();
  end
  initial
  begin
    #300us;
    fail_count++;
    final_report();
  end
endmodule

// [ddrbg_params.svh]
// constants for the byte-lane read gating and termination block
`ifndef DDRBG_PARAMS_SVH
`define DDRBG_PARAMS_SVH

// ==========================================================================
// register byte addresses
`define DDRBG_ADR_W           12
`define DDRBG_PGC_ADDR        12'h008
`define DDRBG_STAT_ADDR       12'h00C
`define DDRBG_GCR_ADDR        12'h240
`define DDRBG_STR_ADDR        12'h254

// ==========================================================================
// register widths and reset values
`define DDRBG_GCR_W           14
`define DDRBG_STR_W           20
`define DDRBG_PGC_W           2
`define DDRBG_GCR_RESET       14'h0681
`define DDRBG_STR_RESET       20'h55000
`define DDRBG_PGC_RESET       2'h0

// ==========================================================================
// general configuration fields
`define DDRBG_GCR_EARLY       13
`define DDRBG_GCR_HOLD_HI     12
`define DDRBG_GCR_HOLD_LO     11
`define DDRBG_GCR_DATA_DYN    10
`define DDRBG_GCR_STRB_DYN    9
`define DDRBG_GCR_DATA_TERM   2
`define DDRBG_GCR_STRB_TERM   1

// ==========================================================================
// strobe timing fields
`define DDRBG_PHASE_LO        12
`define DDRBG_PHASE_W         2
`define DDRBG_LAT_W           3
`define DDRBG_LAT_MAX         3'h5

// ==========================================================================
// phy general configuration fields
`define DDRBG_PGC_DRIFT_DIS   0
`define DDRBG_PGC_COMMON_TERM 1

// ==========================================================================
// read timing in link clock cycles
`define DDRBG_BASE_CYC        4'h2
`define DDRBG_BURST_CYC       4'h2
`define DDRBG_LEAD_EARLY      4'h1
`define DDRBG_LEAD_LATE       4'h2

`endif

// [ddrbg_pkg.sv]
// types for the byte-lane read gating and termination block
package ddrbg_pkg;

  // ========================================================================
  // read sequencer states
  typedef enum logic [1:0]
  {
    DDRBG_IDLE = 2'h0,
    DDRBG_WAIT = 2'h1,
    DDRBG_GATE = 2'h3,
    DDRBG_HOLD = 2'h2
  } ddrbg_state_t;

  // ========================================================================
  // whole state of the top module
  typedef struct packed {
    ddrbg_state_t fsm;
    logic [3:0]   ph_prev;
    logic [13:0]  gcr;
    logic [19:0]  str;
    logic [1:0]   pgc;
    logic [3:0]   cnt;
    logic [1:0]   rank;
    logic [1:0]   gsel;
    logic [2:0]   lat;
    logic         gate;
    logic         odt_win;
    logic         strobe_gated;
    logic         data_term;
    logic         strobe_term;
    logic         ack;
    logic [31:0]  dat;
  } ddrbg_regs_t;

endpackage

// [ddrbg_sdram_model.sv]
// far-side model: phase clocks and a free read strobe
`timescale 1ns/1ps
module ddrbg_sdram_model
(
  output logic clock_phase_0,
  output logic clock_phase_90,
  output logic clock_phase_180,
  output logic clock_phase_270,
  output logic rd_strobe_in
);
  // ==========================================================
  // 200 ns clocks, offset from the system clock
  initial
  begin
    clock_phase_0 = 1'b0;
    #7;
    forever
      #100 clock_phase_0 = ~clock_phase_0;
  end
  // quarter period behind phase 0
  initial
  begin
    clock_phase_90 = 1'b0;
    #57;
    forever
      #100 clock_phase_90 = ~clock_phase_90;
  end
  assign clock_phase_180 = ~clock_phase_0;
  assign clock_phase_270 = ~clock_phase_90;
  // strobe never parks, only the gate may hide it
  initial
  begin
    rd_strobe_in = 1'b0;
    forever
      #30 rd_strobe_in = ~rd_strobe_in;
  end
endmodule

// [ddrbg_sync.sv]
// two flip-flop synchroniser
`timescale 1ns/1ps

module ddrbg_sync
#(
  parameter int WIDTH = 1
)
(
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta;

  // ========================================================================
  // first stage feeds only the second
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta <= '0;
      q    <= '0;
    end
    else
    begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule

// [ddrbg_top.sv]
// byte-lane read strobe gating, system latency and read termination
//
// Function
// RULE1 - gate read strobe with selected phase clock
// RULE2 - phase code picks 90, 180, 270, 0 clock
// RULE3 - phase fields at 19:12, reset 01
// RULE4 - training loads, drift updates, software overrides
// RULE5 - drift update blocked by configuration disable
// RULE6 - latency code adds 0 to 5 cycles
// RULE7 - latency fields reset to zero
// RULE8 - latency fields at bits 11:0
// RULE9 - training sets latency, software may replace
// RULE10 - bit 13 picks two or one cycle lead
// RULE11 - hold field keeps termination 0-3 cycles
// RULE12 - data dynamic bit limits data termination
// RULE13 - strobe dynamic bit limits strobe termination
// RULE14 - data termination ORed with common setting
// RULE15 - strobe termination ORed with common setting
// RULE16 - each read uses its own rank's fields
// RULE17 - config bits 31:14 read zero
//
// Local design decision: the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "ddrbg_params.svh"

module ddrbg_top
(
  input  wire logic        mclk,
  input  wire logic        arst_n,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [11:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        rd_req,
  input  wire logic [1:0]  rd_rank,
  output logic             rd_busy,
  input  wire logic        train_load,
  input  wire logic [7:0]  train_gate_phase,
  input  wire logic [11:0] train_sys_latency,
  input  wire logic        drift_load,
  input  wire logic [7:0]  drift_gate_phase,
  input  wire logic        clock_phase_0,
  input  wire logic        clock_phase_90,
  input  wire logic        clock_phase_180,
  input  wire logic        clock_phase_270,
  input  wire logic        rd_strobe_in,
  output logic             rd_strobe_gated,
  output logic             rd_gate,
  output logic             data_term_out,
  output logic             strobe_term_out
);

  // ========================================================================
  // reset release and pin synchronisers
  logic       rst_sync_n;
  logic [4:0] pin_q;

  ddrbg_sync
  #(
    .WIDTH (1)
  )
  u_rst_sync
  (
    .clk   (mclk),
    .rst_n (arst_n),
    .d     (1'b1),
    .q     (rst_sync_n)
  );

  ddrbg_sync
  #(
    .WIDTH (5)
  )
  u_pin_sync
  (
    .clk   (mclk),
    .rst_n (rst_sync_n),
    .d     ({rd_strobe_in, clock_phase_270, clock_phase_180,
             clock_phase_90, clock_phase_0}),
    .q     (pin_q)
  );

  // ========================================================================
  // state and reset value
  localparam ddrbg_pkg::ddrbg_regs_t RST_STATE = '{
    fsm:          ddrbg_pkg::DDRBG_IDLE,
    ph_prev:      4'h0,
    gcr:          `DDRBG_GCR_RESET,
    str:          `DDRBG_STR_RESET,
    pgc:          `DDRBG_PGC_RESET,
    cnt:          4'h0,
    rank:         2'h0,
    gsel:         2'h0,
    lat:          3'h0,
    gate:         1'b0,
    odt_win:      1'b0,
    strobe_gated: 1'b0,
    data_term:    1'b0,
    strobe_term:  1'b0,
    ack:          1'b0,
    dat:          32'h0000_0000
  };

  ddrbg_pkg::ddrbg_regs_t r;
  ddrbg_pkg::ddrbg_regs_t next_r;

  // ========================================================================
  // byte-lane merge for writes
  function automatic logic [31:0] ddrbg_merge
  (
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0]  sel
  );
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++)
    begin
      if (sel[b])
      begin
        res[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return res;
  endfunction

  // ========================================================================
  // next state
  logic [3:0]  ph;
  logic        strobe_s;
  logic        tick0;
  logic [1:0]  sidx;
  logic        sel_rise;
  logic [3:0]  lead;
  logic [3:0]  pre;
  logic [3:0]  close_at;
  logic [3:0]  hold;
  logic [1:0]  new_phase;
  logic [2:0]  new_lat;
  logic        data_eff;
  logic        strobe_eff;
  logic        bus_req;
  logic [31:0] wr_v;

  always_comb
  begin
    next_r     = r;
    ph         = pin_q[3:0];
    strobe_s   = pin_q[4];
    next_r.ph_prev = ph;
    tick0      = ph[0] & ~r.ph_prev[0];
    // code 00 -> 90, 01 -> 180, 10 -> 270, 11 -> 0
    sidx       = r.gsel + 2'h1; // RULE2
    sel_rise   = ph[sidx] & ~r.ph_prev[sidx];
    lead       = r.gcr[`DDRBG_GCR_EARLY] ? `DDRBG_LEAD_EARLY
                                          : `DDRBG_LEAD_LATE; // RULE10
    pre        = {1'b0, r.lat} + `DDRBG_BASE_CYC; // RULE6
    close_at   = pre + `DDRBG_BURST_CYC;
    hold       = {2'h0, r.gcr[`DDRBG_GCR_HOLD_HI:`DDRBG_GCR_HOLD_LO]};
    new_phase  = r.str[`DDRBG_PHASE_LO + 2*rd_rank +: 2]; // RULE16
    new_lat    = r.str[3*rd_rank +: 3]; // RULE8 RULE16
    bus_req    = wb_cyc_i & wb_stb_i;
    wr_v       = 32'h0000_0000;

    // ----------------------------------------------------------------------
    // training and drift updates
    if (train_load)
    begin
      next_r.str[19:12] = train_gate_phase; // RULE4
      next_r.str[11:0]  = train_sys_latency; // RULE9
    end
    else if (drift_load && !r.pgc[`DDRBG_PGC_DRIFT_DIS]) // RULE5
    begin
      next_r.str[19:12] = drift_gate_phase; // RULE4
    end

    // ----------------------------------------------------------------------
    // wishbone slave: read data at ack, write at the acked edge
    next_r.ack = bus_req & ~r.ack;
    if (bus_req && !r.ack)
    begin
      case (wb_adr_i)
        `DDRBG_GCR_ADDR:
          next_r.dat = {18'h0, r.gcr}; // RULE17
        `DDRBG_STR_ADDR:
          next_r.dat = {12'h000, r.str};
        `DDRBG_PGC_ADDR:
          next_r.dat = {30'h0, r.pgc};
        `DDRBG_STAT_ADDR:
          next_r.dat = {26'h0, r.rank, r.odt_win, r.gate, r.fsm};
        default:
          next_r.dat = 32'h0000_0000;
      endcase
    end
    if (bus_req && r.ack && wb_we_i)
    begin
      case (wb_adr_i)
        `DDRBG_GCR_ADDR:
        begin
          wr_v = ddrbg_merge({18'h0, r.gcr}, wb_dat_i, wb_sel_i);
          next_r.gcr = wr_v[13:0]; // RULE17
        end
        `DDRBG_STR_ADDR:
        begin
          wr_v = ddrbg_merge({12'h000, r.str}, wb_dat_i, wb_sel_i);
          next_r.str = wr_v[19:0]; // RULE4 RULE9
        end
        `DDRBG_PGC_ADDR:
        begin
          wr_v = ddrbg_merge({30'h0, r.pgc}, wb_dat_i, wb_sel_i);
          next_r.pgc = wr_v[1:0];
        end
        default:
        begin
          wr_v = 32'h0000_0000;
        end
      endcase
    end

    // ----------------------------------------------------------------------
    // read sequencer, counted in link clock cycles
    if (r.fsm != ddrbg_pkg::DDRBG_IDLE && tick0 && r.cnt != 4'hF)
    begin
      next_r.cnt = r.cnt + 4'h1;
    end
    case (r.fsm)
      ddrbg_pkg::DDRBG_IDLE:
      begin
        if (rd_req)
        begin
          next_r.rank = rd_rank;
          next_r.gsel = new_phase; // RULE16
          // reserved codes clamp to five cycles
          next_r.lat  = (new_lat > `DDRBG_LAT_MAX) ? `DDRBG_LAT_MAX
                                                   : new_lat; // RULE6
          next_r.cnt  = 4'h0;
          next_r.fsm  = ddrbg_pkg::DDRBG_WAIT;
        end
      end
      ddrbg_pkg::DDRBG_WAIT:
      begin
        if (({1'b0, r.cnt} + {1'b0, lead}) >= {1'b0, pre})
        begin
          next_r.odt_win = 1'b1; // RULE10
        end
        if (r.cnt >= pre && sel_rise)
        begin
          next_r.gate    = 1'b1; // RULE1
          next_r.odt_win = 1'b1;
          next_r.fsm     = ddrbg_pkg::DDRBG_GATE;
        end
      end
      ddrbg_pkg::DDRBG_GATE:
      begin
        if (r.cnt >= close_at && sel_rise)
        begin
          next_r.gate = 1'b0; // RULE1
          next_r.cnt  = 4'h0;
          next_r.fsm  = ddrbg_pkg::DDRBG_HOLD;
        end
      end
      ddrbg_pkg::DDRBG_HOLD:
      begin
        if (r.cnt >= hold)
        begin
          next_r.odt_win = 1'b0; // RULE11
          next_r.fsm     = ddrbg_pkg::DDRBG_IDLE;
        end
      end
      default:
      begin
        next_r.gate    = 1'b0;
        next_r.odt_win = 1'b0;
        next_r.fsm     = ddrbg_pkg::DDRBG_IDLE;
      end
    endcase

    // ----------------------------------------------------------------------
    // gated strobe and termination outputs
    next_r.strobe_gated = strobe_s & r.gate; // RULE1
    data_eff   = r.gcr[`DDRBG_GCR_DATA_TERM]
               | r.pgc[`DDRBG_PGC_COMMON_TERM]; // RULE14
    strobe_eff = r.gcr[`DDRBG_GCR_STRB_TERM]
               | r.pgc[`DDRBG_PGC_COMMON_TERM]; // RULE15
    next_r.data_term   = r.gcr[`DDRBG_GCR_DATA_DYN]
                       ? (r.odt_win & data_eff) : data_eff; // RULE12
    next_r.strobe_term = r.gcr[`DDRBG_GCR_STRB_DYN]
                       ? (r.odt_win & strobe_eff) : strobe_eff; // RULE13
  end

  // ========================================================================
  // state register
  always_ff @(posedge mclk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      r <= RST_STATE; // RULE3 RULE7
    end
    else
    begin
      r <= next_r;
    end
  end

  // ========================================================================
  // outputs
  assign wb_dat_o        = r.dat;
  assign wb_ack_o        = r.ack;
  assign rd_busy         = (r.fsm != ddrbg_pkg::DDRBG_IDLE);
  assign rd_strobe_gated = r.strobe_gated;
  assign rd_gate         = r.gate;
  assign data_term_out   = r.data_term;
  assign strobe_term_out = r.strobe_term;

endmodule

// [ddrbg_top_assertions.sv]
// port assertions for the read gating block
`timescale 1ns/1ps
module ddrbg_checker
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic rd_req,
  input wire logic rd_busy,
  input wire logic rd_gate,
  input wire logic rd_strobe_gated
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!arst_n);
  // ==========================================================
  // read steps
  sequence s_take;
    rd_req && !rd_busy;
  endsequence
  sequence s_open;
    $rose(rd_gate);
  endsequence
  a_ack_answer: assert property
    (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("stray ack");
  a_busy_min: assert property (s_take |=> rd_busy [*8])
    else $error("read too short");
  a_busy_ends: assert property (s_take |=> ##[16:300] !rd_busy)
    else $error("read stuck");
  a_gate_min: assert property (s_open |-> rd_gate [*6])
    else $error("gate too short");
  a_gate_read: assert property (rd_gate |-> rd_busy || $past(rd_busy))
    else $error("gate outside read");
  a_strobe_gate: assert property (rd_strobe_gated |-> $past(rd_gate))
    else $error("strobe outside gate");
endmodule
bind ddrbg_top ddrbg_checker u_chk (.*);
